/* design/flash_link_pkg.sv */
package flash_link_pkg;

    // read opcodes of the serial port
    localparam logic [7:0] OP_ARRAY_READ  = 8'he8;
    localparam logic [7:0] OP_PAGE_READ   = 8'hd2;
    localparam logic [7:0] OP_STATUS_READ = 8'hd7;
    localparam logic [7:0] OP_LOCK_READ   = 8'h35;

    // page-to-buffer transfer and buffer read opcodes
    localparam logic [7:0] OP_XFER_BUF1   = 8'h53;
    localparam logic [7:0] OP_XFER_BUF2   = 8'h55;
    localparam logic [7:0] OP_BUF1_READ   = 8'hd4;
    localparam logic [7:0] OP_BUF2_READ   = 8'hd6;

    // header byte counts after the opcode
    localparam logic [3:0] ADDR_BYTES     = 4'h3;
    localparam logic [3:0] DUMMY_ARRAY    = 4'h4;
    localparam logic [3:0] DUMMY_BUF      = 4'h1;
    localparam logic [3:0] NO_HDR         = 4'h0;
    localparam int         HDR_MAX_BYTES  = 8;
    localparam int         OUT_W          = 8 * HDR_MAX_BYTES;
    localparam int         CMD_ADDR_W     = 32;

    // bit positions inside a serial byte
    localparam logic [2:0] BIT_FIRST      = 3'h0;
    localparam logic [2:0] BIT_LAST       = 3'h7;

    // page geometry
    localparam int PAGE_BITS      = 12;
    localparam int OFF_BITS_STD   = 9;
    localparam int OFF_BITS_BIN   = 8;
    localparam int PAGE_BYTES_STD = 264;
    localparam int PAGE_BYTES_BIN = 256;
    localparam int SECTORS        = 16;

    // host refresh bookkeeping
    localparam int REWRITE_SPAN_DEF = 50000;
    localparam int PE_CNT_W         = 16;

    // bytes that follow the opcode before data flows
    function automatic logic [3:0] hdr_bytes(input logic [7:0] op);
        unique case (op)
            OP_ARRAY_READ, OP_PAGE_READ: hdr_bytes = ADDR_BYTES + DUMMY_ARRAY;
            OP_BUF1_READ, OP_BUF2_READ:  hdr_bytes = ADDR_BYTES + DUMMY_BUF;
            OP_LOCK_READ, OP_XFER_BUF1,
            OP_XFER_BUF2:                hdr_bytes = ADDR_BYTES;
            default:                     hdr_bytes = NO_HDR;
        endcase
    endfunction : hdr_bytes

    // opcodes that return serial data after the header
    function automatic logic has_data(input logic [7:0] op);
        has_data = (op == OP_ARRAY_READ) || (op == OP_PAGE_READ) ||
                   (op == OP_STATUS_READ) || (op == OP_LOCK_READ) ||
                   (op == OP_BUF1_READ) || (op == OP_BUF2_READ);
    endfunction : has_data

    // start address of a page in the 24-bit address field
    function automatic logic [23:0] page_to_addr(input logic [PAGE_BITS-1:0] page,
                                                 input logic bin);
        page_to_addr = 24'(page) << (bin ? OFF_BITS_BIN : OFF_BITS_STD);
    endfunction : page_to_addr

endpackage : flash_link_pkg

/* design/flash_link_if.sv */
`timescale 1ns/100ps
interface flash_link_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_line;

    // released line floats high through a pull-up
    assign miso_line = miso_oe ? miso : 1'b1;

    modport device (input sck, input cs_n, input mosi, output miso, output miso_oe);
    modport host   (output sck, output cs_n, output mosi, input miso_line);
endinterface : flash_link_if

/* design/flash_port.sv */
`timescale 1ns/100ps
module flash_port
    import flash_link_pkg::*;
#(
    parameter bit BINARY_PAGE = 1'b0,    // factory 256-byte page variant
    parameter int NSECT       = SECTORS  // sectors with a lockdown bit
)(
    input  wire logic                    rst,        // async reset, active high
    flash_link_if.device                 link,       // serial pins
    input  wire logic [7:0]              status_in,  // status byte, other domain
    input  wire logic [NSECT-1:0]        lock_in,    // lockdown per sector, other domain
    output logic      [PAGE_BITS-1:0]    mem_page,   // array page being read
    output logic      [OFF_BITS_STD-1:0] mem_off,    // byte offset in that page
    input  wire logic [7:0]              mem_rdata   // array byte at mem_page/mem_off
);

    typedef enum logic [1:0] {
        PH_CMD  = 2'b00,
        PH_HDR  = 2'b01,
        PH_DATA = 2'b10,
        PH_DONE = 2'b11
    } phase_t;

    // per-frame state, cleared whenever the port is deselected
    typedef struct packed {
        phase_t                  phase;
        logic [2:0]              bit_cnt;
        logic [7:0]              sh_in;
        logic [7:0]              op;
        logic [3:0]              hdr_left;
        logic [23:0]             addr;
        logic [PAGE_BITS-1:0]    page;
        logic [OFF_BITS_STD-1:0] off;
    } frame_t;

    // state that outlives a frame
    typedef struct packed {
        logic [PAGE_BITS-1:0] buf_page1;
        logic [PAGE_BITS-1:0] buf_page2;
        logic [7:0]           stat1;
        logic [7:0]           stat2;
        logic [NSECT-1:0]     lock1;
        logic [NSECT-1:0]     lock2;
    } keep_t;

    // falling-edge output state
    typedef struct packed {
        logic [7:0] sh;
        logic       miso;
        logic       oe;
    } tx_t;

    localparam int OFF_BITS = BINARY_PAGE ? OFF_BITS_BIN : OFF_BITS_STD;
    localparam int PAGE_BYTES = BINARY_PAGE ? PAGE_BYTES_BIN : PAGE_BYTES_STD;
    localparam logic [OFF_BITS_STD-1:0] OFF_LAST = OFF_BITS_STD'(PAGE_BYTES - 1);
    localparam logic [OFF_BITS_STD-1:0] OFF_MASK = OFF_BITS_STD'((1 << OFF_BITS) - 1);

    frame_t s;
    frame_t n;
    keep_t  kq;
    keep_t  k;
    tx_t    tq;
    tx_t    t;

    logic       frame_rst;
    logic [7:0] in_byte;
    logic [23:0] addr_next;
    logic       last_bit;
    logic [7:0] src;
    logic       lock_bit;

    // page and offset split follows the configured page size
    function automatic logic [PAGE_BITS-1:0] page_of(input logic [23:0] a);
        page_of = PAGE_BITS'(a >> OFF_BITS);
    endfunction : page_of

    function automatic logic [OFF_BITS_STD-1:0] off_of(input logic [23:0] a);
        off_of = OFF_BITS_STD'(a) & OFF_MASK;
    endfunction : off_of

    // deselect clears the frame, so sck edges without select only step the side-band synchronisers
    assign frame_rst = rst | link.cs_n;

    // rising edge: capture input bits and decode the command
    always_comb begin
        n         = s;
        k         = kq;
        in_byte   = {s.sh_in[6:0], link.mosi};
        addr_next = {s.addr[15:0], in_byte};
        last_bit  = (s.bit_cnt == BIT_LAST);
        // level synchronisers for the slow side-band inputs
        k.stat1   = status_in;
        k.stat2   = kq.stat1;
        k.lock1   = lock_in;
        k.lock2   = kq.lock1;
        n.bit_cnt = s.bit_cnt + 3'h1;
        n.sh_in   = in_byte;
        unique case (s.phase)
            PH_CMD: begin
                // first edge after select starts a fresh opcode
                if (last_bit) begin
                    n.op       = in_byte;
                    n.hdr_left = hdr_bytes(in_byte);
                    if (hdr_bytes(in_byte) != NO_HDR) begin
                        n.phase = PH_HDR;
                    end else if (has_data(in_byte)) begin
                        n.phase = PH_DATA;
                    end else begin
                        n.phase = PH_DONE;
                    end
                end
            end
            PH_HDR: begin
                if (last_bit) begin
                    // only address bytes shift in, dummy bytes are dropped
                    if ((hdr_bytes(s.op) - s.hdr_left) < ADDR_BYTES) begin
                        n.addr = addr_next;
                    end
                    n.hdr_left = s.hdr_left - 4'h1;
                    if (s.hdr_left == 4'h1) begin
                        n.page  = page_of(n.addr);
                        n.off   = off_of(n.addr);
                        n.phase = has_data(s.op) ? PH_DATA : PH_DONE;
                        unique case (s.op)
                            OP_XFER_BUF1: k.buf_page1 = page_of(n.addr);
                            OP_XFER_BUF2: k.buf_page2 = page_of(n.addr);
                            OP_BUF1_READ: n.page = kq.buf_page1;
                            OP_BUF2_READ: n.page = kq.buf_page2;
                            default: ;
                        endcase
                    end
                end
            end
            PH_DATA: begin
                // step the address once the current byte has been fetched
                if (s.bit_cnt == BIT_FIRST) begin
                    if (s.off >= OFF_LAST) begin
                        n.off = '0;
                        // continuous array read runs on into the next page
                        if (s.op == OP_ARRAY_READ) begin
                            n.page = s.page + PAGE_BITS'(1);
                        end
                    end else begin
                        n.off = s.off + OFF_BITS_STD'(1);
                    end
                end
            end
            PH_DONE: ;
        endcase
    end

    always_ff @(posedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    always_ff @(posedge link.sck or posedge rst) begin
        if (rst) begin
            kq <= '0;
        end else begin
            kq <= k;
        end
    end

    // falling edge: choose the data source and shift it out msb first
    always_comb begin
        t        = tq;
        lock_bit = 1'(kq.lock2 >> s.off);
        unique case (s.op)
            OP_STATUS_READ: src = kq.stat2;
            OP_LOCK_READ:   src = {8{lock_bit}};
            default:        src = mem_rdata;
        endcase
        if (s.phase == PH_DATA) begin
            t.oe = 1'b1;
            // new bit appears right at the fall, inside the low phase
            if (s.bit_cnt == BIT_FIRST) begin
                t.miso = src[7];
                t.sh   = {src[6:0], 1'b0};
            end else begin
                t.miso = tq.sh[7];
                t.sh   = {tq.sh[6:0], 1'b0};
            end
        end else begin
            t.oe   = 1'b0;
            t.miso = 1'b0;
        end
    end

    // a leading fall in mode 3 meets phase command and stays quiet
    always_ff @(negedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            tq <= '0;
        end else begin
            tq <= t;
        end
    end

    assign link.miso    = tq.miso;
    assign link.miso_oe = tq.oe;
    assign mem_page     = s.page;
    assign mem_off      = s.off;

endmodule : flash_port

/* design/flash_host.sv */
`timescale 1ns/100ps
// small synchronous fifo; depth must be a power of two
module byte_fifo #(
    parameter int WIDTH = 8,   // word width
    parameter int DEPTH = 16   // words held
)(
    input  wire logic             clk,       // clock
    input  wire logic             rst,       // async reset, active high
    input  wire logic             in_valid,  // write request
    output logic                  in_ready,  // room for a word
    input  wire logic [WIDTH-1:0] in_data,   // write data
    output logic                  out_valid, // word available
    input  wire logic             out_ready, // consumer takes word
    output logic      [WIDTH-1:0] out_data   // oldest word
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } ptr_t;

    ptr_t             q;
    ptr_t             n;
    logic [WIDTH-1:0] mem [DEPTH];

    // extra pointer bit tells full from empty
    always_comb begin
        n         = q;
        in_ready  = !((q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]));
        out_valid = (q.wp != q.rp);
        if (in_valid && in_ready) begin
            n.wp = q.wp + (AW+1)'(1);
        end
        if (out_valid && out_ready) begin
            n.rp = q.rp + (AW+1)'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[q.wp[AW-1:0]] <= in_data;
        end
    end

    assign out_data = mem[q.rp[AW-1:0]];
endmodule : byte_fifo

module flash_host
    import flash_link_pkg::*;
#(
    parameter bit CPOL         = 1'b0,            // idle clock level: 0 mode 0, 1 mode 3
    parameter int HALF         = 4,               // mclk cycles per sck half period, >= 2
    parameter bit BINARY_PAGE  = 1'b0,            // device uses 256-byte pages
    parameter int REWRITE_SPAN = REWRITE_SPAN_DEF,// page ops before refresh is due
    parameter int FIFO_DEPTH   = 16               // read data buffer words
)(
    input  wire logic                 mclk,        // system clock
    input  wire logic                 rst,         // async reset, active high
    flash_link_if.host                link,        // serial pins
    input  wire logic                 cmd_valid,   // command request
    output logic                      cmd_ready,   // host idle, takes command
    input  wire logic [7:0]           cmd_op,      // opcode
    input  wire logic [23:0]          cmd_addr,    // address bytes
    input  wire logic [15:0]          cmd_len,     // data bytes to read
    input  wire logic                 cmd_pe,      // command is a page erase/program
    input  wire logic                 cmd_rewrite, // use refresh pointer as address
    output logic                      rd_valid,    // read byte available
    input  wire logic                 rd_ready,    // consumer takes byte
    output logic      [7:0]           rd_data,     // read byte
    output logic                      busy,        // frame in progress
    output logic                      refresh_due, // span of page ops reached
    output logic      [PAGE_BITS-1:0] rewrite_page // next page to refresh
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LEAD = 3'b001,
        H_LOW  = 3'b010,
        H_HIGH = 3'b011,
        H_TAIL = 3'b100
    } hstate_t;

    typedef struct packed {
        hstate_t              st;
        logic [7:0]           ph;
        logic                 sck;
        logic                 cs_n;
        logic                 mosi;
        logic [OUT_W-1:0]     out_sh;
        logic [19:0]          rises;
        logic [19:0]          nhdr;
        logic [19:0]          total;
        logic [7:0]           rx_sh;
        logic                 push;
        logic                 m1;
        logic                 m2;
        logic [PE_CNT_W-1:0]  pe_cnt;
        logic [PAGE_BITS-1:0] rw_ptr;
        logic                 due;
    } host_t;

    localparam logic [7:0]          HALF_LAST = 8'(HALF - 1);
    localparam logic [PE_CNT_W-1:0] SPAN      = PE_CNT_W'(REWRITE_SPAN);

    host_t       q;
    host_t       n;
    logic        fifo_ready;
    logic        ph_end;
    logic        push_next;
    logic [19:0] fidx;
    logic [23:0] addr;
    logic [3:0]  hb;

    always_comb begin
        n         = q;
        n.push    = 1'b0;
        // two-flop synchroniser on the returning data pin
        n.m1      = link.miso_line;
        n.m2      = q.m1;
        ph_end    = (q.ph == HALF_LAST);
        fidx      = q.rises + 20'h1;
        // the fall after the next rise completes a read byte
        push_next = (fidx > q.nhdr) && (fidx[2:0] == BIT_FIRST);
        hb        = hdr_bytes(cmd_op);
        addr      = cmd_rewrite ? page_to_addr(q.rw_ptr, BINARY_PAGE) : cmd_addr;
        unique case (q.st)
            H_IDLE: begin
                if (cmd_valid) begin
                    n.out_sh = {cmd_op, addr, {(OUT_W - CMD_ADDR_W){1'b0}}};
                    n.mosi   = cmd_op[7]; // first bit set up at select
                    n.nhdr   = 20'({hb + 4'h1, 3'b000});
                    n.total  = 20'({hb + 4'h1, 3'b000}) + 20'({cmd_len, 3'b000});
                    n.rises  = '0;
                    n.ph     = '0;
                    n.rx_sh  = '0;
                    n.cs_n   = 1'b0;
                    n.st     = H_LEAD;
                    // count page ops, saturating
                    if (cmd_pe && (q.pe_cnt != '1)) begin
                        n.pe_cnt = q.pe_cnt + PE_CNT_W'(1);
                    end
                    if (cmd_rewrite) begin
                        n.rw_ptr = q.rw_ptr + PAGE_BITS'(1);
                        // a full pass of rewrites restarts the span
                        if (q.rw_ptr == '1) begin
                            n.pe_cnt = '0;
                        end
                    end
                end
            end
            H_LEAD: begin
                n.ph = q.ph + 8'h1;
                if (ph_end) begin
                    n.ph  = '0;
                    n.sck = 1'b0;
                    n.st  = H_LOW;
                end
            end
            H_LOW: begin
                // clock stalls low while the buffer could not take the byte
                if (!ph_end) begin
                    n.ph = q.ph + 8'h1;
                end else if (!(push_next && !fifo_ready)) begin
                    n.ph    = '0;
                    n.sck   = 1'b1;
                    n.rises = fidx;
                    n.st    = H_HIGH;
                end
            end
            H_HIGH: begin
                n.ph = q.ph + 8'h1;
                // launch one mclk after the rise, clear of the capture edge
                if ((q.ph == 8'h0) && (q.rises < q.nhdr)) begin
                    n.out_sh = q.out_sh << 1;
                    n.mosi   = q.out_sh[OUT_W-2];
                end
                if (ph_end) begin
                    n.ph  = '0;
                    n.sck = 1'b0;
                    // sample the bit driven at the previous fall
                    if (q.rises > q.nhdr) begin
                        n.rx_sh = {q.rx_sh[6:0], q.m2};
                        n.push  = (q.rises[2:0] == BIT_FIRST);
                    end
                    n.st = (q.rises == q.total) ? H_TAIL : H_LOW;
                end
            end
            H_TAIL: begin
                n.ph = q.ph + 8'h1;
                if (ph_end) begin
                    n.ph   = '0;
                    n.cs_n = 1'b1;
                    n.sck  = CPOL;
                    n.mosi = 1'b0;
                    n.st   = H_IDLE;
                end
            end
            default: n.st = H_IDLE;
        endcase
        n.due = (n.pe_cnt >= SPAN);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q      <= '0;
            q.sck  <= CPOL;
            q.cs_n <= 1'b1;
        end else begin
            q <= n;
        end
    end

    byte_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (mclk),
        .rst       (rst),
        .in_valid  (q.push),
        .in_ready  (fifo_ready),
        .in_data   (q.rx_sh),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    assign link.sck     = q.sck;
    assign link.cs_n    = q.cs_n;
    assign link.mosi    = q.mosi;
    assign cmd_ready    = (q.st == H_IDLE);
    assign busy         = (q.st != H_IDLE);
    assign refresh_due  = q.due;
    assign rewrite_page = q.rw_ptr;

endmodule : flash_host

/* tb/flash_link_props.sv */
`timescale 1ns/100ps
// watches the mode 0 link; both parties are design ends
module flash_link_props (
    input wire logic mclk,    // host clock
    input wire logic rst,     // async reset, active high
    input wire logic sck,     // serial clock
    input wire logic cs_n,    // select, active low
    input wire logic mosi,    // host to device
    input wire logic miso,    // device data
    input wire logic miso_oe  // device drive enable
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // clock parked low and device off the line between frames
    property p_idle; cs_n |-> !sck && !miso_oe; endproperty
    a_idle: assert property (p_idle) else $error("link not idle");
    property p_quiet; $fell(cs_n) |-> !miso_oe [*8]; endproperty
    a_quiet: assert property (p_quiet) else $error("early drive");
    property p_out_fall; !cs_n && $changed(miso) |-> $fell(sck); endproperty
    a_out_fall: assert property (p_out_fall) else $error("miso moved off fall");
    property p_oe_fall; $rose(miso_oe) |-> $fell(sck) && !cs_n; endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("drive start off fall");
    // a bit must last the whole period so the host can take it at the next fall
    property p_out_hold; $fell(sck) && !cs_n |=> ($stable(miso) || cs_n) [*3]; endproperty
    a_out_hold: assert property (p_out_hold) else $error("miso bit too short");
    property p_in_stable; $rose(sck) && !cs_n |-> $stable(mosi); endproperty
    a_in_stable: assert property (p_in_stable) else $error("mosi moved at rise");
    property p_launch;
        !cs_n && !$fell(cs_n) && $changed(mosi) |-> sck && $past(sck) && !$past(sck, 2);
    endproperty
    a_launch: assert property (p_launch) else $error("mosi launch off rise");
    property p_high; $rose(sck) |-> sck [*2] ##1 !sck; endproperty
    a_high: assert property (p_high) else $error("sck high phase wrong");
    c_drive: cover property ($rose(miso_oe));
    c_end: cover property ($rose(cs_n));
    c_frame: cover property ($fell(cs_n) ##1 !cs_n [*8]);
endmodule : flash_link_props

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    import flash_link_pkg::*;
    logic        mclk = 1'b0, rst = 1'b0, cmd_valid = 1'b0, cmd_pe = 1'b0;
    logic        cmd_rw = 1'b0, rd_ready = 1'b1;
    logic [7:0]  cmd_op = 8'h00;
    logic [15:0] cmd_len = 16'h0000;
    logic [23:0] addr_v [2] = '{24'h000000, 24'h000000};
    logic [1:0]  rdy, busy, due, rv;
    logic [7:0]  rdat [2];
    logic [11:0] rwp [2], pg [2];
    logic [8:0]  off [2];
    logic [7:0]  rq [2][$];
    int          miscompares = 0, checks = 0, cyc = 0;
    flash_link_if lk [2] ();

    always #50 mclk = ~mclk;
    // end 0: mode 0, 264-byte pages; end 1: mode 3, 256-byte pages
    for (genvar g = 0; g < 2; g++) begin : gi
        flash_host #(.CPOL(g == 1), .HALF(2), .BINARY_PAGE(g == 1), .REWRITE_SPAN(4))
        u_flash_host (.mclk(mclk), .rst(rst), .link(lk[g]), .cmd_valid(cmd_valid),
            .cmd_ready(rdy[g]), .cmd_op(cmd_op), .cmd_addr(addr_v[g]), .cmd_len(cmd_len),
            .cmd_pe(cmd_pe), .cmd_rewrite(cmd_rw), .rd_valid(rv[g]), .rd_ready(rd_ready),
            .rd_data(rdat[g]), .busy(busy[g]), .refresh_due(due[g]), .rewrite_page(rwp[g]));
        flash_port #(.BINARY_PAGE(g == 1)) u_flash_port (.rst(rst), .link(lk[g]),
            .status_in(8'h5a), .lock_in(16'h0005), .mem_page(pg[g]), .mem_off(off[g]),
            .mem_rdata({pg[g][3:0], 4'h0} ^ off[g][7:0]));
        always @(posedge mclk) if (rv[g] && rd_ready) rq[g].push_back(rdat[g]);
    end
    flash_link_props u_flash_link_props (.mclk(mclk), .rst(rst), .sck(lk[0].sck),
        .cs_n(lk[0].cs_n), .mosi(lk[0].mosi), .miso(lk[0].miso), .miso_oe(lk[0].miso_oe));

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // bench memory byte; array read steps page, others wrap in page
    function automatic logic [7:0] exb(input int i, input logic [7:0] op, input int p,
                                       input int o);
        int ps = i ? 256 : 264;
        if (o >= ps) begin
            p = (op == OP_ARRAY_READ) ? p + 1 : p;
            o = o - ps;
        end
        exb = {p[3:0], 4'h0} ^ o[7:0];
    endfunction : exb
    // one command to both ends, waits until frame done and fifo drained
    task automatic run(input logic [7:0] op, input int ap, input int o, input int n,
                       input logic pe, input logic rw);
        do @(posedge mclk); while (rdy !== 2'b11);
        rq[0].delete();
        rq[1].delete();
        cmd_op <= op;
        cmd_len <= 16'(n);
        cmd_pe <= pe;
        cmd_rw <= rw;
        addr_v[0] <= (24'(ap) << 9) | 24'(o);
        addr_v[1] <= (24'(ap) << 8) | 24'(o);
        cmd_valid <= 1'b1;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        do @(posedge mclk); while (busy !== 2'b00 || rv !== 2'b00);
    endtask : run
    task automatic rd(input logic [7:0] op, input int ap, input int ep, input int o,
                      input int n, input logic rw);
        run(op, ap, o, n, 1'b0, rw);
        for (int i = 0; i < 2; i++) begin
            chk("count", 16'(n), 16'(rq[i].size()));
            for (int k = 0; k < n; k++) begin
                chk("rd_data", exb(i, op, ep, o + k), rq[i][k]);
            end
        end
    endtask : rd
    task automatic rdv(input logic [7:0] op, input int n, input logic [7:0] v0, v1);
        run(op, 0, 0, n, 1'b0, 1'b0);
        for (int i = 0; i < 2; i++) begin
            chk("count", 16'(n), 16'(rq[i].size()));
            for (int k = 0; k < n; k++) begin
                chk("rd_data", k % 2 ? v1 : v0, rq[i][k]);
            end
        end
    endtask : rdv
    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    // hang guard, far above the few thousand cycles needed
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            complete_run();
        end
    end

    initial begin
        // a real rising edge, so the port's frame and buffer state reset before any sck
        rst <= 1'b1;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        rd(OP_PAGE_READ, 3, 3, 250, 18, 1'b0);
        // consumer stalls so the fifo fills and the link must wait
        fork
            begin
                rd_ready <= 1'b0;
                repeat (900) @(posedge mclk);
                rd_ready <= 1'b1;
            end
        join_none
        rd(OP_ARRAY_READ, 3, 3, 250, 18, 1'b0);
        rdv(OP_STATUS_READ, 2, 8'h5a, 8'h5a);
        rdv(OP_LOCK_READ, 4, 8'hff, 8'h00);
        rdv(8'h00, 1, 8'hff, 8'hff);
        rd(OP_XFER_BUF1, 7, 7, 0, 0, 1'b0);
        rd(OP_XFER_BUF2, 9, 9, 0, 0, 1'b0);
        rd(OP_BUF1_READ, 0, 7, 3, 2, 1'b0);
        rd(OP_BUF2_READ, 0, 9, 3, 2, 1'b0);
        for (int j = 0; j < 4; j++) begin
            for (int i = 0; i < 2; i++) chk("refresh_due", 16'h0000, 16'(due[i]));
            run(8'h00, 0, 0, 0, 1'b1, 1'b0);
        end
        rd(OP_PAGE_READ, 5, 0, 0, 1, 1'b1);
        rd(OP_PAGE_READ, 5, 1, 0, 1, 1'b1);
        for (int i = 0; i < 2; i++) begin
            chk("refresh_due", 16'h0001, 16'(due[i]));
            chk("rewrite_page", 16'h0002, 16'(rwp[i]));
        end
        complete_run();
    end
endmodule : tb_top
